//--- mcpab_pkg.sv
// Constants for the MCU control and port A/B register bank.
// Assumes a CPU that issues single-cycle register reads and writes.
package mcpab_pkg;

  // Data-space offsets
  localparam logic [7:0] MCPAB_OFF_PINS_A = 8'h20;
  localparam logic [7:0] MCPAB_OFF_DIRA  = 8'h21;
  localparam logic [7:0] MCPAB_OFF_OUTA  = 8'h22;
  localparam logic [7:0] MCPAB_OFF_DIRB  = 8'h24;
  localparam logic [7:0] MCPAB_OFF_OUTB  = 8'h25;
  localparam logic [7:0] MCPAB_OFF_MCUC  = 8'h55;

  // I/O instruction space
  localparam logic [7:0] MCPAB_IO_BASE   = 8'h20;
  localparam logic [7:0] MCPAB_IO_LAST   = 8'h3f;
  localparam logic [7:0] MCPAB_NO_REG    = 8'hff;

  // Control register fields
  localparam int         MCPAB_B_JTAG_OFF = 7;
  localparam int         MCPAB_B_SLP_OFF  = 6;
  localparam int         MCPAB_B_SLP_UNL  = 5;
  localparam int         MCPAB_B_PU_OFF   = 4;
  localparam int         MCPAB_B_VEC_SEL  = 1;
  localparam int         MCPAB_B_VEC_UNL  = 0;

  // Reset values
  localparam logic [7:0] MCPAB_RST_PORT  = 8'h00;
  localparam logic [7:0] MCPAB_RST_MCUC  = 8'h00;

  // Cycle counts
  localparam logic [2:0] MCPAB_UNLOCK_CYC = 3'h4;
  localparam logic [1:0] MCPAB_SLP_CYC    = 2'h3;

endpackage

//--- mcpab_regs.sv
// MCU control register with timed unlock sequences, and port A/B registers.
// Assumes CPU access strobes and pin levels are synchronous to mclk.
//
// Function
// - JTAG enabled when bit clear and fuse
// - JTAG bit needs two equal writes
// - Brownout sleep bit set by unlock pair
// - Brownout sleep bit active after set
// - Brownout sleep bit self-clears after three
// - Detector off only on sleep while active
// - Global pull-up off kills all pull-ups
// - Vector select picks flash or boot start
// - Vector select changes only after unlock
// - Vector unlock clears after four or select
// - Interrupts masked during vector change sequence
// - Masking leaves global interrupt enable untouched
// - Boot lock bits block cross-section interrupts
// - Registers decode in data and I/O space
// - Output registers A and B, reset zero
// - Direction registers A and B, reset zero
// - Pin register reads levels, write toggles
// - Control register at 0x55, bits 3:2 unused
`timescale 1ns/10ps
`default_nettype none

module mcpab_regs
  import mcpab_pkg::*;
(
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       rst_n,
  // CPU register access
  input  wire logic       cpu_io_space,
  input  wire logic [7:0] cpu_addr,
  input  wire logic       cpu_wr,
  input  wire logic       cpu_rd,
  input  wire logic [7:0] cpu_wdata,
  output logic      [7:0] cpu_rdata,
  // Fuses, lock bits and execution state
  input  wire logic       debug_port_fuse,
  input  wire logic       app_boot_lock_bit,
  input  wire logic       boot_boot_lock_bit,
  input  wire logic       exec_in_boot,
  input  wire logic       sleep_exec,
  // Control outputs
  output logic            jtag_enable,
  output logic            vectors_in_boot,
  output logic            irq_block,
  output logic            detector_sleep_off,
  // Port A
  input  wire logic [7:0] port_a_pins,
  output logic      [7:0] port_a_drive,
  output logic      [7:0] port_a_oe,
  output logic      [7:0] port_a_pullup,
  // Port B
  output logic      [7:0] port_b_drive,
  output logic      [7:0] port_b_oe,
  output logic      [7:0] port_b_pullup
);

  logic [1:0] rst_sync_q;
  logic       rst_i_n;
  logic [7:0] off;
  logic       wr_pins_a, wr_dira, wr_outa, wr_dirb, wr_outb, wr_mcuc;
  logic [7:0] port_a_out_q, port_a_dir_q, port_b_out_q, port_b_dir_q;
  logic       jtag_off_q, jtag_pend_q;
  logic [2:0] jtag_cnt_q;
  logic       slp_unl_q, slp_off_q;
  logic [2:0] slp_unl_cnt_q;
  logic [1:0] slp_cnt_q;
  logic       pu_off_q, vec_sel_q, vec_unl_q, vec_post_q;
  logic [2:0] vec_cnt_q;
  logic [7:0] mcuc_rd;
  logic [7:0] rdata_q;
  logic       det_off_q;
  logic       lock_block;

  // Reset release through two flops
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_i_n = rst_sync_q[1];

  // Map an access to its data-space offset
  function automatic logic [7:0] map_off(input logic io, input logic [7:0] a);
    if (!io) begin
      map_off = a;
    end else if (a > MCPAB_IO_LAST) begin
      map_off = MCPAB_NO_REG;
    end else begin
      map_off = a + MCPAB_IO_BASE;
    end
  endfunction

  assign off     = map_off(cpu_io_space, cpu_addr);
  assign wr_pins_a = cpu_wr && (off == MCPAB_OFF_PINS_A);
  assign wr_dira = cpu_wr && (off == MCPAB_OFF_DIRA);
  assign wr_outa = cpu_wr && (off == MCPAB_OFF_OUTA);
  assign wr_dirb = cpu_wr && (off == MCPAB_OFF_DIRB);
  assign wr_outb = cpu_wr && (off == MCPAB_OFF_OUTB);
  assign wr_mcuc = cpu_wr && (off == MCPAB_OFF_MCUC);

  // Port registers; a pin-register write toggles the output bits
  always_ff @(posedge mclk or negedge rst_i_n) begin
    if (!rst_i_n) begin
      port_a_out_q <= MCPAB_RST_PORT;
      port_a_dir_q <= MCPAB_RST_PORT;
      port_b_out_q <= MCPAB_RST_PORT;
      port_b_dir_q <= MCPAB_RST_PORT;
    end else begin
      if (wr_outa) begin
        port_a_out_q <= cpu_wdata;
      end else if (wr_pins_a) begin
        port_a_out_q <= port_a_out_q ^ cpu_wdata;
      end
      if (wr_dira) begin
        port_a_dir_q <= cpu_wdata;
      end
      if (wr_outb) begin
        port_b_out_q <= cpu_wdata;
      end
      if (wr_dirb) begin
        port_b_dir_q <= cpu_wdata;
      end
    end
  end

  // JTAG disable: a second equal write within the window commits it
  always_ff @(posedge mclk or negedge rst_i_n) begin
    if (!rst_i_n) begin
      jtag_off_q  <= MCPAB_RST_MCUC[MCPAB_B_JTAG_OFF];
      jtag_pend_q <= 1'b0;
      jtag_cnt_q  <= 3'h0;
    end else if (wr_mcuc) begin
      if (jtag_cnt_q != 3'h0 && cpu_wdata[MCPAB_B_JTAG_OFF] == jtag_pend_q) begin
        jtag_off_q <= jtag_pend_q;
        jtag_cnt_q <= 3'h0;
      end else begin
        jtag_pend_q <= cpu_wdata[MCPAB_B_JTAG_OFF];
        jtag_cnt_q  <= MCPAB_UNLOCK_CYC;
      end
    end else if (jtag_cnt_q != 3'h0) begin
      jtag_cnt_q <= jtag_cnt_q - 3'h1;
    end
  end

  // Brownout sleep: unlock, then set; the bit lives three cycles
  always_ff @(posedge mclk or negedge rst_i_n) begin
    if (!rst_i_n) begin
      slp_unl_q     <= MCPAB_RST_MCUC[MCPAB_B_SLP_UNL];
      slp_unl_cnt_q <= 3'h0;
      slp_off_q     <= MCPAB_RST_MCUC[MCPAB_B_SLP_OFF];
      slp_cnt_q     <= 2'h0;
    end else begin
      if (wr_mcuc && cpu_wdata[MCPAB_B_SLP_OFF] && cpu_wdata[MCPAB_B_SLP_UNL]) begin
        slp_unl_q     <= 1'b1;
        slp_unl_cnt_q <= MCPAB_UNLOCK_CYC;
      end else if (wr_mcuc && slp_unl_q && cpu_wdata[MCPAB_B_SLP_OFF]) begin
        slp_unl_q     <= 1'b0;
        slp_unl_cnt_q <= 3'h0;
      end else if (slp_unl_cnt_q == 3'h1) begin
        slp_unl_q     <= 1'b0;
        slp_unl_cnt_q <= 3'h0;
      end else if (slp_unl_cnt_q != 3'h0) begin
        slp_unl_cnt_q <= slp_unl_cnt_q - 3'h1;
      end
      if (wr_mcuc && slp_unl_q && cpu_wdata[MCPAB_B_SLP_OFF] && !cpu_wdata[MCPAB_B_SLP_UNL]) begin
        slp_off_q <= 1'b1;
        slp_cnt_q <= MCPAB_SLP_CYC;
      end else if (slp_cnt_q == 2'h1) begin
        slp_off_q <= 1'b0;
        slp_cnt_q <= 2'h0;
      end else if (slp_cnt_q != 2'h0) begin
        slp_cnt_q <= slp_cnt_q - 2'h1;
      end
    end
  end

  // Detector off request only when sleep runs while the bit is active
  always_ff @(posedge mclk or negedge rst_i_n) begin
    if (!rst_i_n) begin
      det_off_q <= 1'b0;
    end else begin
      det_off_q <= sleep_exec && slp_off_q;
    end
  end

  // Pull-up disable, plain bit
  always_ff @(posedge mclk or negedge rst_i_n) begin
    if (!rst_i_n) begin
      pu_off_q <= MCPAB_RST_MCUC[MCPAB_B_PU_OFF];
    end else if (wr_mcuc) begin
      pu_off_q <= cpu_wdata[MCPAB_B_PU_OFF];
    end
  end

  // Vector select with timed unlock; post flag covers the next instruction
  always_ff @(posedge mclk or negedge rst_i_n) begin
    if (!rst_i_n) begin
      vec_sel_q  <= MCPAB_RST_MCUC[MCPAB_B_VEC_SEL];
      vec_unl_q  <= MCPAB_RST_MCUC[MCPAB_B_VEC_UNL];
      vec_cnt_q  <= 3'h0;
      vec_post_q <= 1'b0;
    end else begin
      vec_post_q <= 1'b0;
      if (wr_mcuc && cpu_wdata[MCPAB_B_VEC_UNL]) begin
        vec_unl_q <= 1'b1;
        vec_cnt_q <= MCPAB_UNLOCK_CYC;
      end else if (wr_mcuc && vec_unl_q) begin
        vec_sel_q  <= cpu_wdata[MCPAB_B_VEC_SEL];
        vec_unl_q  <= 1'b0;
        vec_cnt_q  <= 3'h0;
        vec_post_q <= 1'b1;
      end else if (vec_cnt_q == 3'h1) begin
        vec_unl_q <= 1'b0;
        vec_cnt_q <= 3'h0;
      end else if (vec_cnt_q != 3'h0) begin
        vec_cnt_q <= vec_cnt_q - 3'h1;
      end
    end
  end

  // Read path, unused control bits and unmapped offsets read zero
  assign mcuc_rd = {jtag_off_q, slp_off_q, slp_unl_q, pu_off_q,
                    2'b00, vec_sel_q, vec_unl_q};
  always_ff @(posedge mclk or negedge rst_i_n) begin
    if (!rst_i_n) begin
      rdata_q <= 8'h00;
    end else if (cpu_rd) begin
      case (off)
        MCPAB_OFF_PINS_A: rdata_q <= port_a_pins;
        MCPAB_OFF_DIRA:   rdata_q <= port_a_dir_q;
        MCPAB_OFF_OUTA:   rdata_q <= port_a_out_q;
        MCPAB_OFF_DIRB:   rdata_q <= port_b_dir_q;
        MCPAB_OFF_OUTB:   rdata_q <= port_b_out_q;
        MCPAB_OFF_MCUC:   rdata_q <= mcuc_rd;
        default:          rdata_q <= 8'h00;
      endcase
    end
  end
  assign cpu_rdata = rdata_q;

  // Outputs; masking is a separate gate and never touches the I flag
  assign lock_block = (vec_sel_q && app_boot_lock_bit && !exec_in_boot) ||
                      (!vec_sel_q && boot_boot_lock_bit && exec_in_boot);
  assign irq_block          = vec_unl_q || vec_post_q || lock_block;
  assign jtag_enable        = !jtag_off_q && debug_port_fuse;
  assign vectors_in_boot    = vec_sel_q;
  assign detector_sleep_off = det_off_q;
  assign port_a_drive       = port_a_out_q;
  assign port_a_oe          = port_a_dir_q;
  assign port_a_pullup      = ~port_a_dir_q & port_a_out_q & {8{!pu_off_q}};
  assign port_b_drive       = port_b_out_q;
  assign port_b_oe          = port_b_dir_q;
  assign port_b_pullup      = ~port_b_dir_q & port_b_out_q & {8{!pu_off_q}};

  sequence slp_live_s;
    slp_off_q [*3] ##1 !slp_off_q;
  endsequence

  sequence vec_unl_ends_s;
    ##[1:4] !vec_unl_q;
  endsequence

  jtag_guard_a: assert property (@(posedge mclk) disable iff (!rst_i_n)
    $changed(jtag_off_q) |-> $past(wr_mcuc) && $past(jtag_cnt_q) != 3'h0)
    else $error("JTAG bit changed without a second write");

  slp_life_a: assert property (@(posedge mclk) disable iff (!rst_i_n)
    $rose(slp_off_q) |-> slp_live_s)
    else $error("Brownout sleep bit did not live three cycles");

  slp_set_a: assert property (@(posedge mclk) disable iff (!rst_i_n)
    $rose(slp_off_q) |-> $past(slp_unl_q) && $past(wr_mcuc))
    else $error("Brownout sleep bit set without unlock");

  det_sleep_a: assert property (@(posedge mclk) disable iff (!rst_i_n)
    detector_sleep_off |-> $past(sleep_exec) && $past(slp_off_q))
    else $error("Detector turned off without active bit");

  vec_unl_clear_a: assert property (@(posedge mclk) disable iff (!rst_i_n)
    $rose(vec_unl_q) |-> vec_unl_ends_s)
    else $error("Vector unlock not cleared within four cycles");

  vec_sel_guard_a: assert property (@(posedge mclk) disable iff (!rst_i_n)
    $changed(vec_sel_q) |-> $past(vec_unl_q) && $past(wr_mcuc))
    else $error("Vector select changed outside the sequence");

  vec_mask_a: assert property (@(posedge mclk) disable iff (!rst_i_n)
    $fell(vec_unl_q) && $past(wr_mcuc) |-> irq_block)
    else $error("Interrupts unmasked right after select write");

  pullup_off_a: assert property (@(posedge mclk) disable iff (!rst_i_n)
    pu_off_q |-> (port_a_pullup == 8'h00) && (port_b_pullup == 8'h00))
    else $error("Pull-up active while globally disabled");

  pin_toggle_a: assert property (@(posedge mclk) disable iff (!rst_i_n)
    wr_pins_a |=> port_a_out_q == ($past(port_a_out_q) ^ $past(cpu_wdata)))
    else $error("Pin write did not toggle outputs");

  boot_lock_a: assert property (@(posedge mclk) disable iff (!rst_i_n)
    vec_sel_q && app_boot_lock_bit && !exec_in_boot |-> irq_block)
    else $error("Application interrupt not blocked");

endmodule

`default_nettype wire

//--- testbench.sv
// Self-checking testbench for the MCU control and port A/B register bank.
// Assumes the design's own assertions run inside it; single 25 MHz clock.
`timescale 1ns/10ps
`default_nettype none

module testbench;
  import mcpab_pkg::*;

  logic        mclk = 1'b0;
  logic        rst_n = 1'b0;
  logic        cpu_io_space = 1'b0;
  logic  [7:0] cpu_addr = 8'h00;
  logic        cpu_wr = 1'b0;
  logic        cpu_rd = 1'b0;
  logic  [7:0] cpu_wdata = 8'h00;
  logic  [7:0] cpu_rdata;
  logic        debug_port_fuse = 1'b1;
  logic        app_boot_lock_bit = 1'b0;
  logic        boot_boot_lock_bit = 1'b0;
  logic        exec_in_boot = 1'b0;
  logic        sleep_exec = 1'b0;
  logic        jtag_enable, vectors_in_boot, irq_block, detector_sleep_off;
  logic  [7:0] port_a_pins = 8'h00;
  logic  [7:0] port_a_drive, port_a_oe, port_a_pullup;
  logic  [7:0] port_b_drive, port_b_oe, port_b_pullup;
  logic [31:0] lfsr_q = 32'hde7b;
  logic  [7:0] rd_notes [$];
  logic  [7:0] pk_notes [$];
  logic        rd_pend = 1'b0;
  int          pk_sel = 0;
  int          pk_cnt = 0;
  int          pk_seen = 0;
  int          cycles = 0;
  int          compares = 0;
  int          fail_count = 0;
  logic  [7:0] offs [5] = '{MCPAB_OFF_DIRA, MCPAB_OFF_OUTA, MCPAB_OFF_DIRB, MCPAB_OFF_OUTB,
                            MCPAB_OFF_MCUC};

  mcpab_regs DUT (
    .mclk, .rst_n, .cpu_io_space, .cpu_addr, .cpu_wr, .cpu_rd, .cpu_wdata, .cpu_rdata,
    .debug_port_fuse, .app_boot_lock_bit, .boot_boot_lock_bit, .exec_in_boot, .sleep_exec,
    .jtag_enable, .vectors_in_boot, .irq_block, .detector_sleep_off,
    .port_a_pins, .port_a_drive, .port_a_oe, .port_a_pullup,
    .port_b_drive, .port_b_oe, .port_b_pullup
  );

  always #20 mclk = ~mclk;

  function automatic logic [7:0] probe(input int sel);
    case (sel)
      1: return {7'h00, jtag_enable};
      2: return {7'h00, irq_block};
      3: return {7'h00, detector_sleep_off};
      4: return port_a_pullup;
      5: return {7'h00, vectors_in_boot};
      7: return port_a_drive;
      8: return port_a_oe;
      9: return port_b_drive;
      10: return port_b_oe;
      default: return port_b_pullup;
    endcase
  endfunction

  task automatic stop_test();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Watches the outputs; old values are seen before the edge's updates land
  always @(posedge mclk) begin
    if (rd_pend) chk(cpu_rdata, rd_notes.pop_front());
    if (pk_cnt != pk_seen) chk(probe(pk_sel), pk_notes.pop_front());
    pk_seen = pk_cnt;
    rd_pend = cpu_rd;
    cycles++;
    if (cycles == 2000) begin
      fail_count++;
      stop_test();
    end
  end

  task automatic rnd(output logic [7:0] v);
    lfsr_q = {lfsr_q[30:0], lfsr_q[31] ^ lfsr_q[21] ^ lfsr_q[1] ^ lfsr_q[0]};
    v = lfsr_q[7:0];
  endtask

  // One bus cycle, driven at the falling edge and held over the rising one
  task automatic bus(input logic w, input logic r, input logic io, input logic [7:0] a,
                     input logic [7:0] d, input logic s);
    cpu_wr = w;
    cpu_rd = r;
    cpu_io_space = io;
    cpu_addr = a;
    cpu_wdata = d;
    sleep_exec = s;
    @(negedge mclk);
  endtask

  task automatic wr(input logic io, input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, 1'b0, io, a, d, 1'b0);
  endtask

  task automatic ctl(input logic [7:0] d);
    wr(1'b1, 8'h35, d);
  endtask

  task automatic rd(input logic io, input logic [7:0] a, input logic [7:0] e);
    rd_notes.push_back(e);
    bus(1'b0, 1'b1, io, a, 8'h00, 1'b0);
  endtask

  task automatic idle(input int n);
    repeat (n) bus(1'b0, 1'b0, 1'b0, 8'h00, 8'h00, 1'b0);
  endtask

  task automatic sleep1();
    bus(1'b0, 1'b0, 1'b0, 8'h00, 8'h00, 1'b1);
  endtask

  // Output check at the next rising edge
  task automatic peek(input int sel, input logic [7:0] e);
    pk_notes.push_back(e);
    pk_sel = sel;
    pk_cnt++;
  endtask

  initial begin
    logic [7:0] v;
    idle(16);
    rst_n = 1'b1;
    idle(3);
    foreach (offs[i]) rd(1'b0, offs[i], 8'h00);
    for (int i = 0; i < 4; i++) begin
      rnd(v);
      wr(1'b1, offs[i] - MCPAB_IO_BASE, v);
      rd(1'b0, offs[i], v);
    end
    wr(1'b1, 8'h01, 8'h0f);
    wr(1'b0, MCPAB_OFF_OUTA, 8'h3c);
    wr(1'b1, 8'h04, 8'h00);
    wr(1'b1, 8'h05, 8'hff);
    peek(4, 8'h30);
    idle(1);
    peek(6, 8'hff);
    ctl(8'h10);
    peek(4, 8'h00);
    idle(1);
    peek(6, 8'h00);
    rd(1'b1, 8'h35, 8'h10);
    ctl(8'h00);
    // Pin levels and toggling
    rnd(v);
    port_a_pins = v;
    idle(2);
    rd(1'b1, 8'h00, v);
    wr(1'b1, 8'h00, 8'h0f);
    rd(1'b0, MCPAB_OFF_OUTA, 8'h33);
    // I/O addresses above the I/O window reach nothing
    peek(7, 8'h33);
    wr(1'b1, 8'h40, 8'h00);
    peek(8, 8'h0f);
    rd(1'b1, 8'h40, 8'h00);
    peek(9, 8'hff);
    rd(1'b1, 8'h05, 8'hff);
    peek(10, 8'h00);
    idle(5);
    // Debug port disable needs two equal writes inside the window
    peek(1, 8'h01);
    ctl(8'h80);
    idle(4);
    ctl(8'h80);
    peek(1, 8'h01);
    idle(5);
    ctl(8'h80);
    idle(3);
    ctl(8'h80);
    peek(1, 8'h00);
    rd(1'b1, 8'h35, 8'h80);
    ctl(8'h00);
    ctl(8'h00);
    peek(1, 8'h01);
    idle(1);
    debug_port_fuse = 1'b0;
    peek(1, 8'h00);
    idle(1);
    debug_port_fuse = 1'b1;
    // Brown-out off during sleep: live window, self-clear, missing unlock
    ctl(8'h60);
    ctl(8'h40);
    idle(2);
    sleep1();
    peek(3, 8'h01);
    sleep1();
    peek(3, 8'h00);
    idle(5);
    ctl(8'h40);
    sleep1();
    peek(3, 8'h00);
    idle(5);
    // Vector select change with interrupt masking
    ctl(8'h01);
    peek(2, 8'h01);
    ctl(8'h02);
    peek(2, 8'h01);
    idle(1);
    peek(2, 8'h00);
    idle(1);
    peek(5, 8'h01);
    rd(1'b0, MCPAB_OFF_MCUC, 8'h02);
    idle(4);
    ctl(8'h01);
    for (int i = 0; i < 5; i++) begin
      peek(2, (i < 4) ? 8'h01 : 8'h00);
      idle(1);
    end
    ctl(8'h00);
    peek(5, 8'h01);
    ctl(8'h0e);
    rd(1'b1, 8'h35, 8'h02);
    // Lock bits block interrupts outside the vectors' section
    app_boot_lock_bit = 1'b1;
    boot_boot_lock_bit = 1'b1;
    idle(1);
    peek(2, 8'h01);
    idle(1);
    exec_in_boot = 1'b1;
    idle(1);
    peek(2, 8'h00);
    idle(1);
    ctl(8'h01);
    ctl(8'h00);
    peek(5, 8'h00);
    idle(2);
    peek(2, 8'h01);
    idle(2);
    stop_test();
  end

endmodule
`default_nettype wire
